// ===== bctc_cpu_end.sv
// bus cycle termination: processor end that runs and ends each bus cycle
// assumes the slave end keeps its own timing of ack, bus error and halt
`timescale 1ns/1ps
`default_nettype none
`include "bctc_defs.svh"
module bctc_cpu_end (
  // clock and reset
  input  wire logic                    CLK_SYS,
  input  wire logic                    RESETN,
  // bus
  bctc_bus_if.cpu                      bus,
  // cycle request
  input  wire logic                    REQ,
  input  wire logic                    REQ_WRITE,
  input  wire logic                    REQ_RMW,
  input  wire logic [`BCTC_ADDR_W-1:0] REQ_ADDR,
  input  wire logic [`BCTC_FC_W-1:0]   REQ_FC,
  input  wire logic [`BCTC_DATA_W-1:0] REQ_WDATA,
  output logic                         REQ_READY,
  // cycle result
  output logic                         DONE,
  output logic [`BCTC_DATA_W-1:0]      RDATA,
  output logic                         PERIPH_SEEN,
  output logic                         TRAP,
  output logic [7:0]                   TRAP_VECTOR,
  output logic                         HALTED
);
  bctc_pkg::bctc_cpu_state_type state_reg;
  logic [3:0]                   seen;
  logic                         ack_s;
  logic                         bus_error_in_s;
  logic                         halt_s;
  logic                         vpa_s;
  logic                         write_reg;
  logic                         rmw_reg;
  logic [`BCTC_ADDR_W-1:0]      addr_reg;
  logic [`BCTC_FC_W-1:0]        fc_reg;
  logic [`BCTC_DATA_W-1:0]      wdata_reg;
  logic                         rerun_reg;
  logic                         halt_after_reg;
  logic                         bus_error_in_gone_reg;
  logic                         vpa_reg;

  bctc_sampler #(.WIDTH(4)) u_sampler (
    .clk   (CLK_SYS),
    .rst_n (RESETN),
    .in_n  ({bus.peripheral_valid_in_n, bus.halt_n, bus.bus_error_in_n, bus.transfer_acknowledge_n}),
    .seen  (seen)
  );
  assign ack_s  = seen[0];
  assign bus_error_in_s = seen[1];
  assign halt_s = seen[2];
  assign vpa_s  = seen[3];

  // sequencer: one state per clock, each covering a pair of bus states
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      state_reg <= bctc_pkg::ST_IDLE;
    end else begin
      unique case (state_reg)
        bctc_pkg::ST_IDLE: begin
          // lingering bus error or halt from the last cycle holds off the next
          if (REQ && !bus_error_in_s && !halt_s) begin // [RULE9]
            state_reg <= bctc_pkg::ST_S0;
          end
        end
        bctc_pkg::ST_S0: begin
          state_reg <= bctc_pkg::ST_S2;
        end
        bctc_pkg::ST_S2: begin
          state_reg <= bctc_pkg::ST_S4;
        end
        bctc_pkg::ST_S4: begin
          if (bus_error_in_s) begin
            state_reg <= bctc_pkg::ST_S8; // [RULE3] [RULE5]
          end else if (ack_s) begin
            state_reg <= bctc_pkg::ST_S6; // [RULE17] [RULE20]
          end
          // otherwise stay: a wait state of one clock, no limit [RULE14]
        end
        bctc_pkg::ST_S6: begin
          if (bus_error_in_s) begin
            state_reg <= bctc_pkg::ST_S8; // [RULE4] [RULE6] [RULE18]
          end else if (halt_s || halt_after_reg) begin
            state_reg <= bctc_pkg::ST_HALT; // [RULE2]
          end else begin
            state_reg <= bctc_pkg::ST_IDLE; // [RULE1] [RULE21]
          end
        end
        bctc_pkg::ST_S8: begin
          state_reg <= rerun_reg ? bctc_pkg::ST_RERUN : bctc_pkg::ST_BUS_ERROR_IN_WAIT; // [RULE21]
        end
        bctc_pkg::ST_HALT: begin
          if (!halt_s) begin
            state_reg <= bctc_pkg::ST_IDLE; // [RULE2]
          end
        end
        bctc_pkg::ST_RERUN: begin
          if (!halt_s) begin
            state_reg <= bus_error_in_gone_reg ? bctc_pkg::ST_S0 : bctc_pkg::ST_IDLE; // [RULE5] [RULE8]
          end
        end
        bctc_pkg::ST_BUS_ERROR_IN_WAIT: begin
          if (!bus_error_in_s) begin
            state_reg <= bctc_pkg::ST_IDLE; // [RULE3]
          end
        end
        default: begin
          state_reg <= bctc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // cycle attributes are held across a rerun so it repeats exactly
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      write_reg <= 1'b0;
      rmw_reg   <= 1'b0;
      addr_reg  <= '0;
      fc_reg    <= '0;
      wdata_reg <= '0;
    end else if (state_reg == bctc_pkg::ST_IDLE && REQ && !bus_error_in_s && !halt_s) begin
      write_reg <= REQ_WRITE;
      rmw_reg   <= REQ_RMW;
      addr_reg  <= REQ_ADDR; // [RULE22]
      fc_reg    <= REQ_FC;
      wdata_reg <= REQ_WDATA;
    end
  end

  // termination decision: rerun only outside read-modify-write
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      rerun_reg      <= 1'b0;
      halt_after_reg <= 1'b0;
      bus_error_in_gone_reg  <= 1'b0;
      vpa_reg        <= 1'b0;
    end else begin
      if (state_reg == bctc_pkg::ST_S0) begin
        halt_after_reg <= 1'b0;
        vpa_reg        <= 1'b0;
      end else if (state_reg == bctc_pkg::ST_S4 && ack_s && !bus_error_in_s) begin
        halt_after_reg <= halt_s; // [RULE2]
      end
      if (state_reg != bctc_pkg::ST_IDLE && vpa_s) begin
        vpa_reg <= 1'b1; // [RULE19]
      end
      if ((state_reg == bctc_pkg::ST_S4 || state_reg == bctc_pkg::ST_S6) && bus_error_in_s) begin
        rerun_reg <= halt_s && !rmw_reg; // [RULE23]
      end
      // halt must outlast bus error by a clock, else the rerun is illegal
      if (state_reg == bctc_pkg::ST_S8) begin
        bus_error_in_gone_reg <= 1'b0;
      end else if (state_reg == bctc_pkg::ST_RERUN && !bus_error_in_s && halt_s) begin
        bus_error_in_gone_reg <= 1'b1; // [RULE8]
      end
    end
  end

  // bus pins: strobe held S0 through S6, dropped at the end state
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      bus.address_strobe_n    <= 1'b1;
      bus.upper_byte_strobe_n <= 1'b1;
      bus.lower_byte_strobe_n <= 1'b1;
      bus.read_n_write        <= 1'b1;
      bus.rmw_cycle           <= 1'b0;
      bus.addr                <= '0;
      bus.fc                  <= '0;
      bus.cpu_data            <= '0;
      bus.cpu_data_oe         <= 1'b0;
    end else begin
      if (state_reg == bctc_pkg::ST_S0) begin
        bus.address_strobe_n <= 1'b0; // [RULE12]
        bus.read_n_write     <= !write_reg;
        bus.rmw_cycle        <= rmw_reg;
        bus.addr             <= addr_reg;
        bus.fc               <= fc_reg;
        bus.cpu_data         <= wdata_reg;
        bus.cpu_data_oe      <= write_reg;
      end else if (state_reg == bctc_pkg::ST_S2) begin
        // data strobes qualify write data a clock after the address
        bus.upper_byte_strobe_n <= 1'b0; // [RULE12]
        bus.lower_byte_strobe_n <= 1'b0;
      end else if ((state_reg == bctc_pkg::ST_S6 && !bus_error_in_s) || state_reg == bctc_pkg::ST_S8) begin
        bus.address_strobe_n    <= 1'b1; // [RULE21]
        bus.upper_byte_strobe_n <= 1'b1;
        bus.lower_byte_strobe_n <= 1'b1;
        bus.read_n_write        <= 1'b1;
        bus.cpu_data_oe         <= 1'b0;
      end
    end
  end

  // user side results
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      REQ_READY   <= 1'b0;
      DONE        <= 1'b0;
      RDATA       <= '0;
      PERIPH_SEEN <= 1'b0;
      TRAP        <= 1'b0;
      TRAP_VECTOR <= '0;
      HALTED      <= 1'b0;
    end else begin
      REQ_READY <= (state_reg == bctc_pkg::ST_IDLE) && !REQ && !bus_error_in_s && !halt_s;
      DONE      <= (state_reg == bctc_pkg::ST_S6 && !bus_error_in_s && !halt_s && !halt_after_reg) ||
                   (state_reg == bctc_pkg::ST_HALT && !halt_s);
      HALTED    <= (state_reg == bctc_pkg::ST_HALT) || (state_reg == bctc_pkg::ST_RERUN);
      if (state_reg == bctc_pkg::ST_S6 && !write_reg) begin
        RDATA <= bus.slv_data; // [RULE16] [RULE20]
      end
      if (state_reg == bctc_pkg::ST_S6 && !bus_error_in_s) begin
        PERIPH_SEEN <= vpa_reg || vpa_s;
      end
      TRAP <= 1'b0;
      if (state_reg == bctc_pkg::ST_BUS_ERROR_IN_WAIT && !bus_error_in_s) begin
        TRAP        <= 1'b1;
        TRAP_VECTOR <= `BCTC_VEC_BUS_ERROR; // [RULE24]
      end else if (state_reg == bctc_pkg::ST_RERUN && !halt_s && !bus_error_in_gone_reg) begin
        TRAP        <= 1'b1;
        TRAP_VECTOR <= `BCTC_VEC_ILLEGAL; // [RULE8]
      end
    end
  end
endmodule
`default_nettype wire

// ===== bctc_defs.svh
// bus cycle termination: shared constants for both ends of the bus
// assumes a single 40 MHz system clock shared by both ends
// Overview of operation
// [RULE1] ack alone: normal end, next cycle
// [RULE2] halt with ack: finish, then halt
// [RULE3] bus error before ack: abort, trap
// [RULE4] bus error one clock after ack: trap
// [RULE5] halt and bus error: terminate, rerun later
// [RULE6] late halt and bus error: rerun
// [RULE7] bus error negated late; halt outlasts it
// [RULE8] early halt release: illegal, vector zero
// [RULE9] lingering inputs stretch the next cycle
// [RULE10] inputs change on rising clock edge only
// [RULE11] release ack, bus error with strobe
// [RULE12] strobes start cycle; slave answers with ack
// [RULE13] no responder: watchdog raises bus error
// [RULE14] unlimited one clock wait states
// [RULE15] input recognised at next sample edge
// [RULE16] read data taken edge after ack
// [RULE17] early ack: four clock cycle
// [RULE18] late bus error valid one clock after ack
// [RULE19] bus error, peripheral valid sampled from start
// [RULE20] ack sampled from state four; data at six
// [RULE21] end in seven, or nine on error
// [RULE22] rerun repeats address, code and data
// [RULE23] no rerun of read-modify-write
// [RULE24] bus error vector offset eight
`ifndef BCTC_DEFS_SVH
`define BCTC_DEFS_SVH
`define BCTC_ADDR_W         23
`define BCTC_DATA_W         16
`define BCTC_FC_W           3
`define BCTC_VEC_BUS_ERROR  8'h08
`define BCTC_VEC_ILLEGAL    8'h00
`define BCTC_WDOG_CYCLES    8'h10
`define BCTC_HALT_AFTER_BUS_ERROR_IN 4'h1
`endif

// ===== bctc_pkg.sv
// bus cycle termination: state and mode types
// assumes bctc_defs.svh supplies the numbers
package bctc_pkg;
  typedef enum logic [3:0] {
    ST_IDLE, ST_S0, ST_S2, ST_S4, ST_S6, ST_S8, ST_HALT, ST_RERUN, ST_BUS_ERROR_IN_WAIT
  } bctc_cpu_state_type;
  typedef enum logic [2:0] {
    RSP_NORMAL, RSP_HALT, RSP_BUS_ERROR_IN, RSP_LATE_BUS_ERROR_IN, RSP_RERUN, RSP_LATE_RERUN, RSP_NONE
  } bctc_resp_type;
endpackage

// ===== bctc_bus_if.sv
// bus cycle termination: the asynchronous bus between processor and slave
// assumes both ends run on the same clock; each end has its own data lines and enable
`timescale 1ns/1ps
`default_nettype none
`include "bctc_defs.svh"
interface bctc_bus_if;
  logic                     address_strobe_n;
  logic                     upper_byte_strobe_n;
  logic                     lower_byte_strobe_n;
  logic                     read_n_write;
  logic                     rmw_cycle;
  logic [`BCTC_ADDR_W-1:0]  addr;
  logic [`BCTC_FC_W-1:0]    fc;
  logic [`BCTC_DATA_W-1:0]  cpu_data;
  logic                     cpu_data_oe;
  logic [`BCTC_DATA_W-1:0]  slv_data;
  logic                     slv_data_oe;
  logic                     transfer_acknowledge_n;
  logic                     bus_error_in_n;
  logic                     halt_n;
  logic                     peripheral_valid_in_n;
  modport cpu (
    output address_strobe_n, upper_byte_strobe_n, lower_byte_strobe_n, read_n_write, rmw_cycle,
    output addr, fc, cpu_data, cpu_data_oe,
    input  slv_data, slv_data_oe, transfer_acknowledge_n, bus_error_in_n, halt_n, peripheral_valid_in_n
  );
  modport slv (
    input  address_strobe_n, upper_byte_strobe_n, lower_byte_strobe_n, read_n_write, rmw_cycle,
    input  addr, fc, cpu_data, cpu_data_oe,
    output slv_data, slv_data_oe, transfer_acknowledge_n, bus_error_in_n, halt_n, peripheral_valid_in_n
  );
endinterface
`default_nettype wire

// ===== bctc_sampler.sv
// bus cycle termination: registers the control inputs once per clock
// assumes inputs are synchronous to the clock; stands for the falling-edge sample
`timescale 1ns/1ps
`default_nettype none
module bctc_sampler #(
  parameter int WIDTH = 4
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // active-low inputs in, active-high recognised levels out
  input  wire logic [WIDTH-1:0] in_n,
  output logic      [WIDTH-1:0] seen
);
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          seen[gi] <= 1'b0;
        end else begin
          seen[gi] <= ~in_n[gi]; // [RULE15]
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ===== bctc_slave_end.sv
// bus cycle termination: slave plus external termination logic
// assumes the processor end drives the strobes from its clock
`timescale 1ns/1ps
`default_nettype none
`include "bctc_defs.svh"
module bctc_slave_end (
  // clock and reset
  input  wire logic                    CLK_SYS,
  input  wire logic                    RESETN,
  // bus
  bctc_bus_if.slv                      bus,
  // answer selection for the next cycle
  input  wire bctc_pkg::bctc_resp_type MODE,
  input  wire logic [3:0]              WAIT_CYCLES,
  input  wire logic                    RESUME,
  input  wire logic                    PERIPHERAL,
  input  wire logic [`BCTC_DATA_W-1:0] READ_DATA,
  // captured write
  output logic                         WR_STROBE,
  output logic [`BCTC_DATA_W-1:0]      WR_DATA,
  output logic [`BCTC_ADDR_W-1:0]      WR_ADDR
);
  logic                    as_reg;
  logic                    active_reg;
  bctc_pkg::bctc_resp_type mode_reg;
  logic [7:0]              cnt_reg;
  logic                    late_reg;
  logic                    hold_halt_reg;
  logic [3:0]              halt_cnt_reg;
  logic                    wr_done_reg;
  logic                    as_now;
  logic                    fire;

  assign as_now = !bus.address_strobe_n;
  assign fire   = active_reg && as_now &&
                  (mode_reg == bctc_pkg::RSP_NONE ? cnt_reg == `BCTC_WDOG_CYCLES : cnt_reg == {4'h0, WAIT_CYCLES});

  // every control output changes only on the rising clock edge [RULE10]
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      as_reg        <= 1'b0;
      active_reg    <= 1'b0;
      mode_reg      <= bctc_pkg::RSP_NORMAL;
      cnt_reg       <= '0;
      late_reg      <= 1'b0;
      hold_halt_reg <= 1'b0;
      halt_cnt_reg  <= '0;
      bus.transfer_acknowledge_n <= 1'b1;
      bus.bus_error_in_n         <= 1'b1;
      bus.halt_n                 <= 1'b1;
      bus.peripheral_valid_in_n  <= 1'b1;
    end else begin
      as_reg   <= as_now;
      late_reg <= 1'b0;
      if (as_now && !as_reg) begin
        active_reg <= 1'b1;
        mode_reg   <= MODE;
        cnt_reg    <= '0;
        bus.peripheral_valid_in_n <= !PERIPHERAL;
      end else if (active_reg && as_now && !fire) begin
        cnt_reg <= cnt_reg + 8'h01;
      end
      if (fire) begin
        active_reg <= 1'b0;
        unique case (mode_reg)
          bctc_pkg::RSP_NORMAL: bus.transfer_acknowledge_n <= 1'b0; // [RULE12]
          bctc_pkg::RSP_HALT: begin
            bus.transfer_acknowledge_n <= 1'b0;
            bus.halt_n                 <= 1'b0;
          end
          bctc_pkg::RSP_BUS_ERROR_IN, bctc_pkg::RSP_NONE: bus.bus_error_in_n <= 1'b0; // [RULE13]
          bctc_pkg::RSP_RERUN: begin
            bus.bus_error_in_n <= 1'b0; // [RULE5]
            bus.halt_n         <= 1'b0;
          end
          bctc_pkg::RSP_LATE_BUS_ERROR_IN, bctc_pkg::RSP_LATE_RERUN: begin
            bus.transfer_acknowledge_n <= 1'b0;
            late_reg                   <= 1'b1;
          end
          default: bus.transfer_acknowledge_n <= 1'b0;
        endcase
      end
      // late error follows the ack by exactly one clock
      if (late_reg) begin
        bus.bus_error_in_n <= 1'b0; // [RULE18]
        if (mode_reg == bctc_pkg::RSP_LATE_RERUN) begin
          bus.halt_n <= 1'b0;
        end
      end
      // release with the strobe; halt kept on past the bus error for reruns [RULE11] [RULE7]
      if (!as_now && as_reg) begin
        bus.transfer_acknowledge_n <= 1'b1;
        bus.bus_error_in_n         <= 1'b1;
        bus.peripheral_valid_in_n  <= 1'b1;
        hold_halt_reg <= (mode_reg == bctc_pkg::RSP_RERUN) || (mode_reg == bctc_pkg::RSP_LATE_RERUN);
        halt_cnt_reg  <= '0;
      end
      // rerun: halt outlasts bus error by at least one clock [RULE7]
      if (hold_halt_reg) begin
        if (halt_cnt_reg == `BCTC_HALT_AFTER_BUS_ERROR_IN) begin
          bus.halt_n    <= 1'b1;
          hold_halt_reg <= 1'b0;
        end else begin
          halt_cnt_reg <= halt_cnt_reg + 4'h1;
        end
      end else if (RESUME && !as_now && mode_reg == bctc_pkg::RSP_HALT) begin
        bus.halt_n <= 1'b1;
      end
    end
  end

  // data: drive reads while strobed, capture a write once per cycle [RULE12]
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      bus.slv_data    <= '0;
      bus.slv_data_oe <= 1'b0;
      wr_done_reg     <= 1'b0;
      WR_STROBE       <= 1'b0;
      WR_DATA         <= '0;
      WR_ADDR         <= '0;
    end else begin
      bus.slv_data    <= READ_DATA;
      bus.slv_data_oe <= as_now && bus.read_n_write;
      WR_STROBE       <= 1'b0;
      if (!as_now) begin
        wr_done_reg <= 1'b0;
      end else if (!bus.read_n_write && !bus.upper_byte_strobe_n && !wr_done_reg) begin
        wr_done_reg <= 1'b1;
        WR_STROBE   <= 1'b1;
        WR_DATA     <= bus.cpu_data;
        WR_ADDR     <= bus.addr;
      end
    end
  end
endmodule
`default_nettype wire

// ===== bctc_props.sv
// bus cycle termination: concurrent checks on the bus joining the two ends
// assumes every input is wired straight to the matching bus interface signal
`timescale 1ns/1ps
`default_nettype none
`include "bctc_defs.svh"
module bctc_props (
  // clock and reset
  input wire logic                    CLK_SYS,
  input wire logic                    RESETN,
  // processor side
  input wire logic                    address_strobe_n,
  input wire logic                    upper_byte_strobe_n,
  input wire logic                    lower_byte_strobe_n,
  input wire logic                    read_n_write,
  input wire logic                    rmw_cycle,
  input wire logic [`BCTC_ADDR_W-1:0] addr,
  input wire logic [`BCTC_FC_W-1:0]   fc,
  input wire logic                    cpu_data_oe,
  // slave side
  input wire logic                    slv_data_oe,
  input wire logic                    transfer_acknowledge_n,
  input wire logic                    bus_error_in_n,
  input wire logic                    halt_n
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);

  logic                    as_q;
  logic                    rerun_pend;
  logic [`BCTC_ADDR_W-1:0] last_addr;
  logic [`BCTC_FC_W-1:0]   last_fc;

  // remembers the cycle that a bus error with halt must repeat
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      as_q       <= 1'h1;
      rerun_pend <= 1'h0;
      last_addr  <= '0;
      last_fc    <= '0;
    end else begin
      as_q <= address_strobe_n;
      if (as_q && !address_strobe_n) begin
        rerun_pend <= 1'h0;
        last_addr  <= addr;
        last_fc    <= fc;
      end else if (!address_strobe_n && !bus_error_in_n && !halt_n && !rmw_cycle) begin
        rerun_pend <= 1'h1;
      end
    end
  end

  strobe_pair_a:
    assert property (upper_byte_strobe_n == lower_byte_strobe_n && (!address_strobe_n || upper_byte_strobe_n))
      else $error("byte strobes apart or active without address strobe");
  data_dir_a:
    assert property (!(cpu_data_oe && slv_data_oe) && (!cpu_data_oe || !read_n_write))
      else $error("data bus driven in the wrong direction");
  ack_end_a:
    assert property (!address_strobe_n && !transfer_acknowledge_n && halt_n |-> ##[1:4] address_strobe_n)
      else $error("cycle not ended after acknowledge");
  bus_error_in_end_a:
    assert property (!address_strobe_n && !bus_error_in_n && transfer_acknowledge_n |-> ##[1:4] address_strobe_n)
      else $error("cycle not aborted after bus error");
  wait_hold_a:
    assert property (!address_strobe_n && transfer_acknowledge_n && bus_error_in_n
                     && $past(transfer_acknowledge_n) && $past(bus_error_in_n) |=> !address_strobe_n)
      else $error("cycle ended with no answer");
  halt_stall_a:
    assert property ((address_strobe_n && !halt_n) [*5] |=> address_strobe_n)
      else $error("cycle started while halted");
  rerun_hold_a:
    assert property ($rose(bus_error_in_n) && !$past(halt_n) |-> !halt_n)
      else $error("halt released together with bus error");
  ack_release_a:
    assert property (address_strobe_n [*3] |-> transfer_acknowledge_n && bus_error_in_n)
      else $error("acknowledge or bus error held after strobe");
  rerun_same_a:
    assert property (as_q && !address_strobe_n && rerun_pend |-> addr == last_addr && fc == last_fc)
      else $error("rerun cycle differs from the first one");
endmodule
`default_nettype wire

// ===== tb.sv
// bus cycle termination: self-checking bench for both ends of the bus
// assumes the design files and bctc_props.sv are compiled before this file
`timescale 1ns/1ps
`default_nettype none
`include "bctc_defs.svh"
module tb;
  typedef struct {
    bctc_pkg::bctc_resp_type mode;
    logic wr, rmw, per, trap;
    logic [3:0] wt;
    logic [`BCTC_ADDR_W-1:0] addr;
    logic [`BCTC_DATA_W-1:0] dat;
    logic [7:0] vec;
  } bctc_row_type;

  // mode, write, rmw, peripheral, trap, waits, address, data, vector
  bctc_row_type rows [10] = '{
    '{bctc_pkg::RSP_NORMAL,     1'h0, 1'h0, 1'h0, 1'h0, 4'h0, 23'h000100, 16'hA5C3, 8'h00},
    '{bctc_pkg::RSP_NORMAL,     1'h1, 1'h0, 1'h0, 1'h0, 4'h0, 23'h000104, 16'h5A3C, 8'h00},
    '{bctc_pkg::RSP_NORMAL,     1'h0, 1'h0, 1'h1, 1'h0, 4'h3, 23'h000108, 16'h0FF0, 8'h00},
    '{bctc_pkg::RSP_HALT,       1'h0, 1'h0, 1'h0, 1'h0, 4'h1, 23'h00010C, 16'h1234, 8'h00},
    '{bctc_pkg::RSP_BUS_ERROR_IN,       1'h0, 1'h0, 1'h0, 1'h1, 4'h0, 23'h000110, 16'h0000, 8'h08},
    '{bctc_pkg::RSP_LATE_BUS_ERROR_IN,  1'h0, 1'h0, 1'h0, 1'h1, 4'h0, 23'h000114, 16'h0000, 8'h08},
    '{bctc_pkg::RSP_RERUN,      1'h1, 1'h0, 1'h0, 1'h0, 4'h2, 23'h000118, 16'hBEEF, 8'h00},
    '{bctc_pkg::RSP_LATE_RERUN, 1'h0, 1'h0, 1'h0, 1'h0, 4'h0, 23'h00011C, 16'hC0DE, 8'h00},
    '{bctc_pkg::RSP_NONE,       1'h0, 1'h0, 1'h0, 1'h1, 4'h0, 23'h000120, 16'h0000, 8'h08},
    '{bctc_pkg::RSP_RERUN,      1'h0, 1'h1, 1'h0, 1'h1, 4'h0, 23'h000124, 16'h0000, 8'h08}
  };

  logic                    clk, resetn, req, req2, req_write, req_rmw, resume, peripheral;
  logic                    req_ready, done, periph_seen, trap, halted, wr_strobe, trap2;
  logic                    f_bus_error_in_n, f_halt_n;
  logic [`BCTC_ADDR_W-1:0] req_addr, wr_addr;
  logic [`BCTC_FC_W-1:0]   req_fc;
  logic [`BCTC_DATA_W-1:0] req_wdata, rdata, read_data, wr_data;
  logic [7:0]              trap_vec, vec2;
  logic [3:0]              wait_cycles;
  bctc_pkg::bctc_resp_type mode;
  int                      n_mismatch, checked;

  bctc_bus_if bus ();
  bctc_bus_if bus2 ();

  bctc_cpu_end bctc_cpu_end_i (.CLK_SYS(clk), .RESETN(resetn), .bus(bus.cpu), .REQ(req),
    .REQ_WRITE(req_write), .REQ_RMW(req_rmw), .REQ_ADDR(req_addr), .REQ_FC(req_fc), .REQ_WDATA(req_wdata),
    .REQ_READY(req_ready), .DONE(done), .RDATA(rdata), .PERIPH_SEEN(periph_seen), .TRAP(trap),
    .TRAP_VECTOR(trap_vec), .HALTED(halted));
  bctc_slave_end bctc_slave_end_i (.CLK_SYS(clk), .RESETN(resetn), .bus(bus.slv), .MODE(mode),
    .WAIT_CYCLES(wait_cycles), .RESUME(resume), .PERIPHERAL(peripheral), .READ_DATA(read_data),
    .WR_STROBE(wr_strobe), .WR_DATA(wr_data), .WR_ADDR(wr_addr));
  bctc_props bctc_props_i (.CLK_SYS(clk), .RESETN(resetn), .address_strobe_n(bus.address_strobe_n),
    .upper_byte_strobe_n(bus.upper_byte_strobe_n), .lower_byte_strobe_n(bus.lower_byte_strobe_n),
    .read_n_write(bus.read_n_write), .rmw_cycle(bus.rmw_cycle), .addr(bus.addr), .fc(bus.fc),
    .cpu_data_oe(bus.cpu_data_oe), .slv_data_oe(bus.slv_data_oe), .halt_n(bus.halt_n),
    .transfer_acknowledge_n(bus.transfer_acknowledge_n), .bus_error_in_n(bus.bus_error_in_n));

  // second processor faces a faulty terminator that releases halt too early
  bctc_cpu_end bctc_cpu_end_i2 (.CLK_SYS(clk), .RESETN(resetn), .bus(bus2.cpu), .REQ(req2),
    .REQ_WRITE(req_write), .REQ_RMW(req_rmw), .REQ_ADDR(req_addr), .REQ_FC(req_fc), .REQ_WDATA(req_wdata),
    .REQ_READY(), .DONE(), .RDATA(), .PERIPH_SEEN(), .TRAP(trap2), .TRAP_VECTOR(vec2), .HALTED());
  // undriven data lines toggle so a stale value is never mistaken for data
  assign bus2.slv_data               = {16{clk}};
  assign bus2.slv_data_oe            = 1'h0;
  assign bus2.transfer_acknowledge_n = 1'h1;
  assign bus2.peripheral_valid_in_n  = 1'h1;
  assign bus2.bus_error_in_n         = f_bus_error_in_n;
  assign bus2.halt_n                 = f_halt_n;

  always #12.5 clk = ~clk;

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task test_done;
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic wait_ready;
    int n = 0;
    while (req_ready !== 1'h1 && n < 100) begin
      @(negedge clk);
      n++;
    end
  endtask

  task automatic run_row(input bctc_row_type r);
    int   n, hc;
    logic saw_halt;
    logic saw_wr = 1'h0;
    @(negedge clk);
    mode        = r.mode;
    wait_cycles = r.wt;
    peripheral  = r.per;
    read_data   = r.dat;
    req_write   = r.wr;
    req_rmw     = r.rmw;
    req_addr    = r.addr;
    req_wdata   = r.dat;
    req_fc      = 3'h5;
    wait_ready();
    req = 1'h1;
    @(negedge clk);
    req      = 1'h0;
    n        = 1;
    hc       = 0;
    saw_halt = 1'h0;
    while (done !== 1'h1 && trap !== 1'h1 && n < 200) begin
      // stay halted a while so a stalled start would show on the bus
      if (halted === 1'h1) begin
        saw_halt = 1'h1;
        mode     = bctc_pkg::RSP_NORMAL;
        hc++;
        if (hc > 6) resume = 1'h1;
      end
      saw_wr |= wr_strobe;
      @(negedge clk);
      n++;
    end
    resume = 1'h0;
    check(trap, r.trap);
    check({done | trap, saw_wr, saw_halt}, {1'h1, r.wr, !r.rmw && r.mode inside
      {bctc_pkg::RSP_HALT, bctc_pkg::RSP_RERUN, bctc_pkg::RSP_LATE_RERUN}});
    if (r.trap) check(trap_vec, r.vec);
    else if (r.wr) check({wr_addr, wr_data}, {r.addr, r.dat});
    else check(rdata, r.dat);
    if (r.mode == bctc_pkg::RSP_NORMAL) begin
      check(n, 7 + r.wt);
      check(periph_seen, r.per);
    end
  endtask

  initial begin
    #100000;
    n_mismatch++;
    test_done();
  end

  initial begin
    int n;
    clk = 1'h0; resetn = 1'h0; req = 1'h0; req2 = 1'h0; req_write = 1'h0; req_rmw = 1'h0;
    req_addr = '0; req_fc = '0; req_wdata = '0; resume = 1'h0; peripheral = 1'h0;
    read_data = '0; wait_cycles = 4'h0; mode = bctc_pkg::RSP_NORMAL; f_bus_error_in_n = 1'h1; f_halt_n = 1'h1;
    n_mismatch = 0; checked = 0;
    repeat (12) @(negedge clk);
    check({bus.address_strobe_n, bus.upper_byte_strobe_n, bus.cpu_data_oe, req_ready, done, halted}, 6'h30);
    resetn = 1'h1;
    $display("reset test done");
    for (int i = 0; i < 10; i++) begin
      run_row(rows[i]);
      $display("row %0d done", i);
    end
    // halt released together with bus error on the faulty side
    @(negedge clk);
    req_rmw = 1'h0;
    req2    = 1'h1;
    n       = 0;
    while (bus2.address_strobe_n !== 1'h0 && n < 20) begin
      @(negedge clk);
      n++;
    end
    req2     = 1'h0;
    f_bus_error_in_n = 1'h0;
    f_halt_n = 1'h0;
    repeat (4) @(negedge clk);
    f_bus_error_in_n = 1'h1;
    f_halt_n = 1'h1;
    n        = 0;
    while (trap2 !== 1'h1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    check({trap2, vec2}, 9'h100);
    $display("illegal release test done");
    // reset in mid-cycle must drop the strobes at once
    mode = bctc_pkg::RSP_NONE;
    wait_ready();
    req = 1'h1;
    @(negedge clk);
    req = 1'h0;
    repeat (3) @(negedge clk);
    check(bus.address_strobe_n, 1'h0);
    resetn = 1'h0;
    #1;
    check({bus.address_strobe_n, bus.upper_byte_strobe_n, bus.cpu_data_oe}, 3'h6);
    repeat (2) @(negedge clk);
    resetn = 1'h1;
    run_row(rows[0]);
    $display("mid-cycle reset test done");
    test_done();
  end
endmodule
`default_nettype wire
